// [inc/cifs_pkg.sv]
package cifs_pkg;

  // Register word offsets (byte addresses on a 32-bit Avalon-MM bus).
  localparam logic [4:0] ADDR_PAYLOAD_CMP  = 5'h00;
  localparam logic [4:0] ADDR_CAUSE        = 5'h04;
  localparam logic [4:0] ADDR_FIFO_CFG     = 5'h08;
  localparam logic [4:0] ADDR_FIFO_PTR     = 5'h0C;
  localparam logic [4:0] ADDR_FLAGS        = 5'h10;
  localparam logic [4:0] ADDR_ENABLES      = 5'h14;
  localparam logic [4:0] ADDR_PAYLOAD_SET  = 5'h18;

  // Field positions.
  localparam int MATCHED_FILTER_NUMBER_LSB   = 8;
  localparam int SIZE_LSB     = 13;
  localparam int WPTR_LSB     = 8;
  localparam int TX_BO_BIT    = 13;
  localparam int TX_BP_BIT    = 12;
  localparam int RX_BP_BIT    = 11;
  localparam int TX_WAR_BIT   = 10;
  localparam int RX_WAR_BIT   = 9;
  localparam int ANY_WAR_BIT  = 8;
  localparam int IVR_BIT      = 7;
  localparam int WAK_BIT      = 6;
  localparam int ERR_BIT      = 5;
  localparam int FIFO_BIT     = 3;
  localparam int RBOV_BIT     = 2;
  localparam int RB_BIT       = 1;
  localparam int TB_BIT       = 0;

  // Flag write mask, compare count limit and reserved size code.
  localparam logic [7:0] FLAG_MASK   = 8'hEF;
  localparam logic [4:0] CMP_MAX     = 5'h11;
  localparam logic [2:0] SIZE_RSVD   = 3'h7;

  // Cause codes.
  localparam logic [6:0] CODE_NONE     = 7'h40;
  localparam logic [6:0] CODE_ERROR    = 7'h41;
  localparam logic [6:0] CODE_WAKE     = 7'h42;
  localparam logic [6:0] CODE_OVERFLOW = 7'h43;
  localparam logic [6:0] CODE_FIFO     = 7'h44;

  // Reset values, plus read data for unused fields and unmapped addresses.
  localparam logic [4:0]  RST_CMP   = 5'h00;
  localparam logic [4:0]  RST_HIT   = 5'h00;
  localparam logic [2:0]  RST_SIZE  = 3'h0;
  localparam logic [4:0]  RST_START = 5'h00;
  localparam logic [5:0]  RST_PTR   = 6'h00;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAP  = 32'hDEAD_0000;

endpackage : cifs_pkg

// [verilog/cifs_top.sv]
`timescale 1ns/10ps
// Operation
// - Five-bit compare count; zero disables compare.
// - Count 1 to 17 selects compare extent.
// - Report matched filter number 0 to 15.
// - Cause code for none, error, wake, overflow, fifo.
// - Buffer interrupt cause equals buffer index.
// - Three-bit size field selects buffer count.
// - Five-bit field selects first FIFO buffer.
// - Six-bit FIFO write pointer readable.
// - Six-bit FIFO read pointer readable.
// - Bus-off and error-passive status bits.
// - Warning bits plus combined warning bit.
// - Error flag raised from error-state bits.
// - Invalid message flag, clear only.
// - Wake-up flag, clear only.
// - FIFO almost full flag, clear only.
// - Receive overflow flag, clear only.
// - Receive and transmit buffer flags, clear only.
// - Enable register mirrors flag positions, resets zero.
// - Unimplemented bits read zero, ignore writes.
// - Flags kept and wake settable when disabled.
module cifs_top #(
  parameter int BUF_IDX_W = 6
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 module_disabled,
  input  wire logic                 tx_bus_off,
  input  wire logic                 tx_error_passive,
  input  wire logic                 rx_error_passive,
  input  wire logic                 tx_warning,
  input  wire logic                 rx_warning,
  input  wire logic                 invalid_msg_event,
  input  wire logic                 wakeup_event,
  input  wire logic                 fifo_almost_full_event,
  input  wire logic                 rx_overflow_event,
  input  wire logic                 rx_buffer_event,
  input  wire logic                 tx_buffer_event,
  input  wire logic [3:0]           event_buffer_index,
  input  wire logic                 rx_match_valid,
  input  wire logic [3:0]           rx_match_filter,
  input  wire logic                 fifo_write_done,
  input  wire logic                 fifo_read_done,
  output logic      [2:0]           buffer_area_size,
  output logic      [5:0]           buffer_count,
  output logic      [4:0]           fifo_start_buffer,
  output logic      [4:0]           payload_compare_count,
  output logic      [BUF_IDX_W-1:0] fifo_write_pointer,
  output logic      [BUF_IDX_W-1:0] fifo_read_pointer,
  output logic      [6:0]           interrupt_cause_code,
  output logic                      interrupt_pending
);

  typedef enum logic [1:0] {
    CIFS_IDLE = 2'b00,
    CIFS_ACK  = 2'b01
  } cifs_bus_t;

  cifs_bus_t        bus_q;
  logic [4:0]       matched_filter_number_q;
  logic [2:0]       size_q;
  logic [4:0]       start_q;
  logic [4:0]       cmp_q;
  logic [BUF_IDX_W-1:0] wptr_q;
  logic [BUF_IDX_W-1:0] rptr_q;
  logic [7:0]       flags_q;
  logic [7:0]       flags_d;
  logic [7:0]       enables_q;
  logic [3:0]       last_buf_q;
  logic             last_buf_rx_q;
  logic [5:0]       err_state;
  logic [31:0]      rdata_d;
  logic [31:0]      avs_readdata_q;
  logic [6:0]       code_d;
  logic [6:0]       code_q;
  logic [7:0]       pend;
  logic             wr_acc;
  logic [7:0]       clr_mask;

  // Maps the size code to the number of buffers in the shared area.
  function automatic logic [5:0] size_to_count(input logic [2:0] code);
    case (code)
      3'h0:    size_to_count = 6'h04;
      3'h1:    size_to_count = 6'h06;
      3'h2:    size_to_count = 6'h08;
      3'h3:    size_to_count = 6'h0C;
      3'h4:    size_to_count = 6'h10;
      3'h5:    size_to_count = 6'h18;
      3'h6:    size_to_count = 6'h20;
      default: size_to_count = 6'h20;
    endcase
  endfunction : size_to_count

  // Advances a FIFO pointer, wrapping from the area end to its start.
  function automatic logic [BUF_IDX_W-1:0] ptr_next(input logic [BUF_IDX_W-1:0] p,
                                                    input logic [4:0] start,
                                                    input logic [5:0] count);
    logic [BUF_IDX_W-1:0] nx;
    nx = p + BUF_IDX_W'(1);
    if (nx >= BUF_IDX_W'(count) || nx < BUF_IDX_W'(start)) begin
      ptr_next = BUF_IDX_W'(start);
    end else begin
      ptr_next = nx;
    end
  endfunction : ptr_next

  assign err_state = {tx_bus_off, tx_error_passive, rx_error_passive,
                      tx_warning, rx_warning, tx_warning | rx_warning};

  // Single wait state: the request is accepted on the second edge after it rises.
  assign avs_waitrequest = (avs_read | avs_write) & (bus_q == CIFS_IDLE);
  assign wr_acc          = avs_write & (bus_q == CIFS_ACK);
  assign avs_readdata    = avs_readdata_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= CIFS_IDLE;
    end else if (clk_en) begin
      if (bus_q == CIFS_ACK) begin
        bus_q <= CIFS_IDLE;
      end else if (avs_read | avs_write) begin
        bus_q <= CIFS_ACK;
      end
    end
  end

  // Configuration registers; writes to reserved bits are dropped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      size_q    <= cifs_pkg::RST_SIZE;
      start_q   <= cifs_pkg::RST_START;
      enables_q <= cifs_pkg::RST_FLAGS;
      cmp_q     <= cifs_pkg::RST_CMP;
    end else if (clk_en && wr_acc) begin
      case (avs_address)
        cifs_pkg::ADDR_FIFO_CFG: begin
          if (avs_byteenable[1] &&
              avs_writedata[cifs_pkg::SIZE_LSB +: 3] != cifs_pkg::SIZE_RSVD) begin
            size_q <= avs_writedata[cifs_pkg::SIZE_LSB +: 3];
          end
          if (avs_byteenable[0]) begin
            start_q <= avs_writedata[4:0];
          end
        end
        cifs_pkg::ADDR_ENABLES: begin
          if (avs_byteenable[0]) begin
            enables_q <= avs_writedata[7:0] & cifs_pkg::FLAG_MASK;
          end
        end
        cifs_pkg::ADDR_PAYLOAD_SET: begin
          if (avs_byteenable[0] && avs_writedata[4:0] <= cifs_pkg::CMP_MAX) begin
            cmp_q <= avs_writedata[4:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Matched filter number from the receive path.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      matched_filter_number_q <= cifs_pkg::RST_HIT;
    end else if (clk_en && rx_match_valid) begin
      matched_filter_number_q <= {1'b0, rx_match_filter};
    end
  end

  // FIFO pointers walk inside the area from the start buffer to the last buffer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= BUF_IDX_W'(cifs_pkg::RST_PTR);
      rptr_q <= BUF_IDX_W'(cifs_pkg::RST_PTR);
    end else if (clk_en) begin
      if (wr_acc && avs_address == cifs_pkg::ADDR_FIFO_CFG && avs_byteenable[0]) begin
        wptr_q <= BUF_IDX_W'(avs_writedata[4:0]);
        rptr_q <= BUF_IDX_W'(avs_writedata[4:0]);
      end else begin
        if (fifo_write_done) begin
          wptr_q <= ptr_next(wptr_q, start_q, size_to_count(size_q));
        end
        if (fifo_read_done) begin
          rptr_q <= ptr_next(rptr_q, start_q, size_to_count(size_q));
        end
      end
    end
  end

  // Clear-only flags: a write of 0 clears, hardware set wins over the clear.
  always_comb begin
    clr_mask = 8'h00;
    if (wr_acc && avs_address == cifs_pkg::ADDR_FLAGS && avs_byteenable[0]) begin
      clr_mask = ~avs_writedata[7:0] & cifs_pkg::FLAG_MASK;
    end
    flags_d = flags_q & ~clr_mask;
    flags_d[cifs_pkg::IVR_BIT]  = flags_d[cifs_pkg::IVR_BIT] | invalid_msg_event;
    flags_d[cifs_pkg::WAK_BIT]  = flags_d[cifs_pkg::WAK_BIT] | wakeup_event;
    flags_d[cifs_pkg::ERR_BIT]  = flags_d[cifs_pkg::ERR_BIT] | (|err_state);
    flags_d[cifs_pkg::FIFO_BIT] = flags_d[cifs_pkg::FIFO_BIT] | fifo_almost_full_event;
    flags_d[cifs_pkg::RBOV_BIT] = flags_d[cifs_pkg::RBOV_BIT] | rx_overflow_event;
    flags_d[cifs_pkg::RB_BIT]   = flags_d[cifs_pkg::RB_BIT] | rx_buffer_event;
    flags_d[cifs_pkg::TB_BIT]   = flags_d[cifs_pkg::TB_BIT] | tx_buffer_event;
    if (module_disabled) begin
      flags_d = flags_q | ({8'h00} | (8'h01 << cifs_pkg::WAK_BIT) & {8{wakeup_event}});
      flags_d = flags_d & ~clr_mask;
      flags_d[cifs_pkg::WAK_BIT] = flags_d[cifs_pkg::WAK_BIT] | wakeup_event;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= cifs_pkg::RST_FLAGS;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  // Remembers which buffer raised the latest buffer event.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_buf_q    <= 4'h0;
      last_buf_rx_q <= 1'b0;
    end else if (clk_en && (rx_buffer_event || tx_buffer_event)) begin
      last_buf_q    <= event_buffer_index;
      last_buf_rx_q <= rx_buffer_event;
    end
  end

  // Cause code, highest priority first among enabled pending flags.
  assign pend = flags_q & enables_q;

  always_comb begin
    if (pend[cifs_pkg::ERR_BIT]) begin
      code_d = cifs_pkg::CODE_ERROR;
    end else if (pend[cifs_pkg::WAK_BIT]) begin
      code_d = cifs_pkg::CODE_WAKE;
    end else if (pend[cifs_pkg::RBOV_BIT]) begin
      code_d = cifs_pkg::CODE_OVERFLOW;
    end else if (pend[cifs_pkg::FIFO_BIT]) begin
      code_d = cifs_pkg::CODE_FIFO;
    end else if (pend[cifs_pkg::RB_BIT] || pend[cifs_pkg::TB_BIT]) begin
      code_d = {3'b000, last_buf_q};
    end else begin
      code_d = cifs_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= cifs_pkg::CODE_NONE;
    end else if (clk_en) begin
      code_q <= code_d;
    end
  end

  // Read mux; unimplemented fields read as zero.
  always_comb begin
    rdata_d = cifs_pkg::RD_ZERO;
    case (avs_address)
      cifs_pkg::ADDR_PAYLOAD_CMP: rdata_d[4:0] = cmp_q;
      cifs_pkg::ADDR_CAUSE: begin
        rdata_d[cifs_pkg::MATCHED_FILTER_NUMBER_LSB +: 5] = matched_filter_number_q;
        rdata_d[6:0] = code_q;
      end
      cifs_pkg::ADDR_FIFO_CFG: begin
        rdata_d[cifs_pkg::SIZE_LSB +: 3] = size_q;
        rdata_d[4:0] = start_q;
      end
      cifs_pkg::ADDR_FIFO_PTR: begin
        rdata_d[cifs_pkg::WPTR_LSB +: 6] = 6'(wptr_q);
        rdata_d[5:0] = 6'(rptr_q);
      end
      cifs_pkg::ADDR_FLAGS: begin
        rdata_d[cifs_pkg::ANY_WAR_BIT +: 6] = err_state;
        rdata_d[7:0] = flags_q;
      end
      cifs_pkg::ADDR_ENABLES: rdata_d[7:0] = enables_q;
      cifs_pkg::ADDR_PAYLOAD_SET: rdata_d[4:0] = cmp_q;
      default: rdata_d = cifs_pkg::RD_UNMAP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_q <= cifs_pkg::RD_ZERO;
    end else if (clk_en && avs_read && bus_q == CIFS_IDLE) begin
      avs_readdata_q <= rdata_d;
    end
  end

  // Registered outputs to the rest of the controller.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buffer_area_size      <= cifs_pkg::RST_SIZE;
      buffer_count          <= 6'h04;
      fifo_start_buffer     <= cifs_pkg::RST_START;
      payload_compare_count <= cifs_pkg::RST_CMP;
      fifo_write_pointer    <= BUF_IDX_W'(cifs_pkg::RST_PTR);
      fifo_read_pointer     <= BUF_IDX_W'(cifs_pkg::RST_PTR);
      interrupt_cause_code  <= cifs_pkg::CODE_NONE;
      interrupt_pending     <= 1'b0;
    end else if (clk_en) begin
      buffer_area_size      <= size_q;
      buffer_count          <= size_to_count(size_q);
      fifo_start_buffer     <= start_q;
      payload_compare_count <= cmp_q;
      fifo_write_pointer    <= wptr_q;
      fifo_read_pointer     <= rptr_q;
      interrupt_cause_code  <= code_q;
      interrupt_pending     <= |pend;
    end
  end

endmodule : cifs_top

// [dv/cifs_top_chk.sv]
`timescale 1ns/10ps
module cifs_top_chk (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       wakeup_event,
  input wire logic       tx_bus_off,
  input wire logic       rx_warning,
  input wire logic [2:0] buffer_area_size,
  input wire logic [5:0] buffer_count,
  input wire logic [4:0] payload_compare_count,
  input wire logic [5:0] fifo_write_pointer,
  input wire logic [6:0] interrupt_cause_code,
  input wire logic       interrupt_pending
);
  logic [5:0] cnt_exp;
  always_comb begin
    case (buffer_area_size)
      3'h0: cnt_exp = 6'h04;
      3'h1: cnt_exp = 6'h06;
      3'h2: cnt_exp = 6'h08;
      3'h3: cnt_exp = 6'h0C;
      3'h4: cnt_exp = 6'h10;
      3'h5: cnt_exp = 6'h18;
      default: cnt_exp = 6'h20;
    endcase
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence err_seen; tx_bus_off || rx_warning; endsequence
  sequence code_err; interrupt_cause_code == cifs_pkg::CODE_ERROR; endsequence
  chk_count_map: assert property (buffer_count == cnt_exp)
    else $error("buffer count does not match size code");
  chk_size_legal: assert property (buffer_area_size != 3'h7)
    else $error("reserved size code taken");
  chk_cmp_range: assert property (payload_compare_count <= 5'h11)
    else $error("compare count out of range");
  chk_code_legal: assert property (interrupt_cause_code <= 7'h0F ||
    (interrupt_cause_code >= 7'h40 && interrupt_cause_code <= 7'h44)) else $error("reserved cause code");
  chk_wptr_range: assert property (!fifo_write_pointer[5])
    else $error("write pointer beyond buffer 31");
  chk_err_code: assert property (err_seen |-> ##[1:4] code_err)
    else $error("error state without error cause");
  chk_wake_code: assert property (wakeup_event |-> ##[1:4] interrupt_cause_code != cifs_pkg::CODE_NONE)
    else $error("wake event without cause");
  chk_reset_vals: assert property ($rose(rst_n) |-> interrupt_cause_code == cifs_pkg::CODE_NONE
    && !interrupt_pending && buffer_count == 6'h04) else $error("bad values after reset");
endmodule : cifs_top_chk

// [dv/cifs_can_node.sv]
`timescale 1ns/10ps
module cifs_can_node (
  input  wire logic       clk_sys,
  output logic      [5:0] evt,
  output logic      [3:0] idx,
  output logic            hit_v,
  output logic            wr_done,
  output logic            rd_done
);
  initial begin
    evt = 6'h00;
    idx = 4'h0;
    {hit_v, wr_done, rd_done} = 3'h0;
  end
  // One-cycle bus event; the released index shows the inverse value.
  task automatic pulse(input logic [5:0] e, input logic [3:0] ix, input logic [2:0] hwr);
    @(posedge clk_sys);
    evt <= e;
    idx <= ix;
    {hit_v, wr_done, rd_done} <= hwr;
    @(posedge clk_sys);
    evt <= 6'h00;
    idx <= ~ix;
    {hit_v, wr_done, rd_done} <= 3'h0;
  endtask : pulse
endmodule : cifs_can_node

// [dv/cifs_top_tb.sv]
`timescale 1ns/10ps
module cifs_top_tb;
  logic        clk_sys, rst_n, dis, rd_q, wr_q, wait_s, pend;
  logic [4:0]  addr, err;
  logic [31:0] wdat, rdat;
  logic [5:0]  evt, bcnt;
  logic [3:0]  idx;
  logic        hit_v, wr_done, rd_done;
  int          miscompares, check_count, cycles;
  cifs_can_node node (.clk_sys(clk_sys), .evt(evt), .idx(idx), .hit_v(hit_v), .wr_done(wr_done),
    .rd_done(rd_done));
  cifs_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .avs_address(addr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wait_s), .module_disabled(dis), .tx_bus_off(err[4]), .tx_error_passive(err[3]),
    .rx_error_passive(err[2]), .tx_warning(err[1]), .rx_warning(err[0]), .invalid_msg_event(evt[5]),
    .wakeup_event(evt[4]), .fifo_almost_full_event(evt[3]), .rx_overflow_event(evt[2]),
    .rx_buffer_event(evt[1]), .tx_buffer_event(evt[0]), .event_buffer_index(idx), .rx_match_valid(hit_v),
    .rx_match_filter(idx), .fifo_write_done(wr_done), .fifo_read_done(rd_done), .buffer_area_size(),
    .buffer_count(bcnt), .fifo_start_buffer(), .payload_compare_count(), .fifo_write_pointer(),
    .fifo_read_pointer(), .interrupt_cause_code(), .interrupt_pending(pend));
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until a rising edge samples waitrequest low, takes read data there, then releases.
  task automatic acc(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    {addr, wdat, wr_q, rd_q} <= {a, d, we, !we};
    @(posedge clk_sys);
    while (wait_s !== 1'b0) begin
      @(posedge clk_sys);
    end
    q = rdat;
    {wr_q, rd_q} <= 2'h0;
    @(posedge clk_sys);
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rchk
  task automatic t_size;
    logic [5:0] tbl [7] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20};
    for (int i = 0; i < 7; i++) begin
      wr(5'h08, {16'hFFFF, i[2:0], 13'h1FE3});
      rchk(5'h08, {16'h0, i[2:0], 13'h0003});
      chk(bcnt, tbl[i]);
    end
    wr(5'h08, 32'hE003);
    rchk(5'h08, 32'hC003);
    wr(5'h08, 32'h0002);
    rchk(5'h0C, 32'h0202);
    for (int i = 0; i < 2; i++) node.pulse(6'h0, 4'h0, 3'h2);
    rchk(5'h0C, 32'h0202);
    node.pulse(6'h0, 4'h0, 3'h3);
    rchk(5'h0C, 32'h0303);
  endtask : t_size
  task automatic t_flags;
    logic [7:0] fb [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
    logic [6:0] cd [6] = '{7'h07, 7'h0F, 7'h43, 7'h44, 7'h42, 7'h40};
    logic [3:0] ix [6] = '{4'h7, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0};
    wr(5'h14, 32'hFFFF);
    rchk(5'h14, 32'hEF);
    for (int i = 0; i < 6; i++) begin
      node.pulse(6'h01 << i, ix[i], 3'h0);
      repeat (3) @(posedge clk_sys);
      chk(pend, 1'b1);
      rchk(5'h10, {24'h0, fb[i]});
      rchk(5'h04, {19'h0, 5'h0F, 1'b0, cd[i]});
      wr(5'h10, {24'h0, ~fb[i]});
      rchk(5'h10, 32'h0);
    end
    node.pulse(6'h08, 4'h0, 3'h0);
    dis <= 1'b1;
    node.pulse(6'h10, 4'h0, 3'h0);
    rchk(5'h10, 32'h48);
    wr(5'h14, 32'h0);
    @(posedge clk_sys);
    chk(pend, 1'b0);
    dis <= 1'b0;
    wr(5'h10, 32'h0);
    wr(5'h14, 32'h20);
    for (int i = 0; i < 5; i++) begin
      err <= 5'h01 << i;
      repeat (4) @(posedge clk_sys);
      rchk(5'h10, {18'h0, err, err[1] | err[0], 8'h20});
      rchk(5'h04, 32'h0F41);
      err <= 5'h0;
      wr(5'h10, 32'hDF);
      rchk(5'h10, 32'h0);
    end
  endtask : t_flags
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    {rst_n, dis, rd_q, wr_q, addr, err, wdat} = '0;
    {miscompares, check_count, cycles} = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk(5'h04, 32'h40);
    rchk(5'h10, 32'h0);
    rchk(5'h1C, 32'hDEAD0000);
    t_size();
    wr(5'h18, 32'h11);
    rchk(5'h00, 32'h11);
    wr(5'h18, 32'h12);
    rchk(5'h00, 32'h11);
    node.pulse(6'h0, 4'hF, 3'h4);
    rchk(5'h04, 32'h0F40);
    t_flags();
    stop_test();
  end
endmodule : cifs_top_tb
bind cifs_top cifs_top_chk chk (.*);
